// file: wrap_home_pkg.sv
/*
  constants for the position wrap and home input block: register offsets,
  field positions, reset values and widths.
  assumes a 32-bit avalon-mm register bus with byte addresses.
*/
package wrap_home_pkg;
  // register byte offsets
  localparam logic [7:0] ctrl_off   = 8'h00;
  localparam logic [7:0] range_off  = 8'h04;
  localparam logic [7:0] ratio_off  = 8'h08;
  localparam logic [7:0] offset_off = 8'h0c;
  localparam logic [7:0] res_off    = 8'h10;
  localparam logic [7:0] pos_off    = 8'h14;
  localparam logic [7:0] remote_off = 8'h18;
  localparam logic [7:0] map_off    = 8'h1c;
  localparam logic [7:0] status_off = 8'h20;
  // control fields
  localparam int ctrl_wrap_bit  = 0;
  localparam int ctrl_two_bit   = 1;
  localparam int ctrl_pulse_bit = 2;
  // remote input fields
  localparam int remote_home_bit = 0;
  // input map fields, 4-bit selectors
  localparam int map_start_pos = 0;
  localparam int map_sens_pos  = 4;
  localparam int map_plus_pos  = 8;
  localparam int map_minus_pos = 12;
  localparam logic [3:0] sel_unused   = 4'hf;
  localparam logic [3:0] pulse_in_top = 4'h3;
  // reset values, ratio limit and unmapped read value
  localparam logic [2:0]  ctrl_reset   = 3'h1;
  localparam logic [15:0] range_reset  = 16'h000a;
  localparam logic [13:0] ratio_reset  = 14'h1388;
  localparam logic [13:0] ratio_max    = 14'h2710;
  localparam logic [29:0] offset_reset = 30'h00000000;
  localparam logic [15:0] res_reset    = 16'h03e8;
  localparam logic [15:0] map_reset    = 16'h9873;
  localparam logic [31:0] unmapped_val = 32'h00000000;
endpackage

// file: wrap_home.sv
/*
  position coordinate wrap unit and return-to-home input set of a stepping
  motor driver, with an avalon-mm slave for its settings.
  assumes step_pulse and step_dir come from motion logic on core_clk, and
  direct_input pins are asynchronous to core_clk.
*/
// Notes on behaviour
// RL1: wrap enabled reloads position past the range
// RL2: wrap enable 0 off, 1 on, resets on
// RL3: wrap range in revolutions, default 10
// RL4: offset ratio 0..10000 in 0.01 percent, default 5000
// RL5: signed 30-bit step offset, default zero
// RL6: ratio shifts window toward negative coordinates
// RL7: three-sensor homing uses sensor, limits, start
// RL8: two-sensor mode frees the home sensor input
// RL9: homing start from direct or remote input
// RL10: sensors stay on direct inputs when remote
// RL11: pulse variant reserves direct inputs 0 to 3
// RL12: host keeps span and range integer related
// RL13: host re-home_sensor_input after wrap setting changes
// RL14: window bounds reload at opposite bound
`timescale 1ns/1ps
module wrap_home #(
  parameter int din_n = 10
) (
  input  wire logic                core_clk,
  input  wire logic                resetn,
  input  wire logic [7:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest,
  input  wire logic                step_pulse,
  input  wire logic                step_dir,
  input  wire logic [din_n-1:0]    direct_input,
  output logic signed [31:0]       position,
  output logic                     wrap_zero_output,
  output logic                     home_start,
  output logic                     home_sensor_input,
  output logic                     plus_limit_input,
  output logic                     minus_limit_input,
  output logic                     fast_homing_cmd
);
  // picks one direct input; unused, out of range or pulse-reserved reads 0
  function automatic logic pick(input logic [3:0] sel, input logic [din_n-1:0] v, input logic pulse);
    logic r;
    r = 1'b0;
    if (sel != wrap_home_pkg::sel_unused && int'(sel) < din_n &&
        !(pulse && sel <= wrap_home_pkg::pulse_in_top))
      r = v[sel];
    return r;
  endfunction

  logic [2:0]          ctrl_reg;
  logic [15:0]         range_reg;
  logic [13:0]         ratio_reg;
  logic [29:0]         offset_reg;
  logic [15:0]         res_reg;
  logic [15:0]         map_reg;
  logic                remote_reg;
  logic signed [31:0]  pos_reg;
  logic [din_n-1:0]    sync1_reg;
  logic [din_n-1:0]    sync2_reg;
  logic                wait_reg;
  logic [31:0]         rdata_reg;
  logic                zero_reg;
  logic                start_reg;
  logic                sens_reg;
  logic                plus_reg;
  logic                minus_reg;
  logic                fast_reg;

  // bus decode
  wire        req      = avs_read | avs_write;
  wire        wr_take  = avs_write & ~wait_reg;
  wire        full_wr  = &avs_byteenable;
  wire        wr_ctrl  = wr_take & full_wr & (avs_address == wrap_home_pkg::ctrl_off);
  wire        wr_range = wr_take & full_wr & (avs_address == wrap_home_pkg::range_off);
  wire        wr_ratio = wr_take & full_wr & (avs_address == wrap_home_pkg::ratio_off);
  wire        wr_off   = wr_take & full_wr & (avs_address == wrap_home_pkg::offset_off);
  wire        wr_res   = wr_take & full_wr & (avs_address == wrap_home_pkg::res_off);
  wire        wr_pos   = wr_take & full_wr & (avs_address == wrap_home_pkg::pos_off);
  wire        wr_rem   = wr_take & full_wr & (avs_address == wrap_home_pkg::remote_off);
  wire        wr_map   = wr_take & full_wr & (avs_address == wrap_home_pkg::map_off);

  // ratio writes above full scale saturate [RL4]
  wire [13:0] ratio_in = (avs_writedata[31:14] != 18'h00000 || avs_writedata[13:0] > wrap_home_pkg::ratio_max)
                         ? wrap_home_pkg::ratio_max : avs_writedata[13:0];

  // wrap window: span steps, shifted negative by span*ratio/10000 [RL3] [RL6] [RL14]
  // host keeps range*res below 2^31, else the window bounds overflow
  wire [31:0]        span      = range_reg * res_reg;
  wire [45:0]        neg_prod  = span * ratio_reg;
  wire [31:0]        neg_part  = 32'(neg_prod / 46'(wrap_home_pkg::ratio_max));
  wire signed [31:0] off_ext   = {{2{offset_reg[29]}}, offset_reg};
  wire signed [31:0] lower     = off_ext - $signed(neg_part);
  wire signed [31:0] upper     = lower + $signed(span);
  wire               wrap_on   = ctrl_reg[wrap_home_pkg::ctrl_wrap_bit];
  wire signed [31:0] pos_inc   = pos_reg + 32'sh1;
  wire signed [31:0] pos_dec   = pos_reg - 32'sh1;

  // next position with wrap reload at the opposite bound [RL1] [RL14]
  wire signed [31:0] pos_step  = !step_dir
                                 ? ((wrap_on && pos_inc >= upper) ? lower : pos_inc)
                                 : ((wrap_on && pos_dec < lower) ? upper - 32'sh1 : pos_dec);
  wire signed [31:0] pos_next  = wr_pos ? $signed(avs_writedata) : (step_pulse ? pos_step : pos_reg);
  wire               zero_next = step_pulse & !wr_pos & (pos_step == 32'sh0) & wrap_on;

  // home input selection; pulse variant blocks inputs 0..3 [RL11]
  wire        pulse_var = ctrl_reg[wrap_home_pkg::ctrl_pulse_bit];
  wire        two_mode  = ctrl_reg[wrap_home_pkg::ctrl_two_bit];
  wire        d_start   = pick(map_reg[wrap_home_pkg::map_start_pos +: 4], sync2_reg, pulse_var);
  wire        d_sens    = pick(map_reg[wrap_home_pkg::map_sens_pos +: 4], sync2_reg, pulse_var);
  wire        d_plus    = pick(map_reg[wrap_home_pkg::map_plus_pos +: 4], sync2_reg, pulse_var);
  wire        d_minus   = pick(map_reg[wrap_home_pkg::map_minus_pos +: 4], sync2_reg, pulse_var);

  // read mux
  wire [31:0] status_w  = {27'h0, fast_reg, minus_reg, plus_reg, sens_reg, start_reg};
  logic [31:0] rdata_next;
  always_comb begin
    case (avs_address)
      wrap_home_pkg::ctrl_off:   rdata_next = {29'h0, ctrl_reg};
      wrap_home_pkg::range_off:  rdata_next = {16'h0, range_reg};
      wrap_home_pkg::ratio_off:  rdata_next = {18'h0, ratio_reg};
      wrap_home_pkg::offset_off: rdata_next = off_ext;
      wrap_home_pkg::res_off:    rdata_next = {16'h0, res_reg};
      wrap_home_pkg::pos_off:    rdata_next = pos_reg;
      wrap_home_pkg::remote_off: rdata_next = {31'h0, remote_reg};
      wrap_home_pkg::map_off:    rdata_next = {16'h0, map_reg};
      wrap_home_pkg::status_off: rdata_next = status_w;
      default:                   rdata_next = wrap_home_pkg::unmapped_val;
    endcase
  end

  // bus handshake: waitrequest drops one cycle after the request rises
  // every request sees exactly one wait cycle, reads and writes alike
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h0;
    end else begin
      wait_reg  <= !(req && wait_reg);
      if (avs_read && wait_reg) rdata_reg <= rdata_next;
    end
  end

  // settings registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg   <= wrap_home_pkg::ctrl_reset; // wrap on at reset [RL2]
      range_reg  <= wrap_home_pkg::range_reset; // [RL3]
      ratio_reg  <= wrap_home_pkg::ratio_reset; // [RL4]
      offset_reg <= wrap_home_pkg::offset_reset; // [RL5]
      res_reg    <= wrap_home_pkg::res_reset;
      map_reg    <= wrap_home_pkg::map_reset;
      remote_reg <= 1'b0;
    end else begin
      if (wr_ctrl)  ctrl_reg   <= avs_writedata[2:0]; // bit0: 0 off, 1 on [RL2]
      if (wr_range) range_reg  <= avs_writedata[15:0];
      if (wr_ratio) ratio_reg  <= ratio_in; // [RL4]
      if (wr_off)   offset_reg <= avs_writedata[29:0]; // signed steps [RL5]
      if (wr_res)   res_reg    <= avs_writedata[15:0];
      if (wr_map)   map_reg    <= avs_writedata[15:0];
      if (wr_rem)   remote_reg <= avs_writedata[wrap_home_pkg::remote_home_bit];
    end
  end

  // position counter and zero-crossing pulse
  // a bus preset wins over a step in the same cycle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pos_reg  <= 32'sh0;
      zero_reg <= 1'b0;
    end else begin
      pos_reg  <= pos_next; // [RL1]
      zero_reg <= zero_next;
    end
  end

  // direct input synchroniser, two stages
  // only the second stage feeds logic; the first may still be settling
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= direct_input;
      sync2_reg <= sync1_reg;
    end
  end

  // home signal outputs
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      start_reg <= 1'b0;
      sens_reg  <= 1'b0;
      plus_reg  <= 1'b0;
      minus_reg <= 1'b0;
      fast_reg  <= 1'b0;
    end else begin
      start_reg <= d_start | remote_reg; // either source starts homing [RL9] [RL7]
      sens_reg  <= d_sens & !two_mode; // sensor ignored in two-sensor mode [RL8]
      plus_reg  <= d_plus; // limits only from direct pins [RL10] [RL7]
      minus_reg <= d_minus;
      fast_reg  <= d_sens & two_mode; // freed input becomes fast homing [RL8]
    end
  end

  // outputs straight from their flip-flops
  assign avs_readdata      = rdata_reg;
  assign avs_waitrequest   = wait_reg;
  assign position          = pos_reg;
  assign wrap_zero_output  = zero_reg;
  assign home_start        = start_reg;
  assign home_sensor_input = sens_reg;
  assign plus_limit_input  = plus_reg;
  assign minus_limit_input = minus_reg;
  assign fast_homing_cmd   = fast_reg;
endmodule

// file: host_pins.sv
/*
  host-side pin model: a controller that drives the direct input pins.
  assumes want is set by the bench on core_clk.
*/
`timescale 1ns/1ps
module host_pins (
  input  wire logic       core_clk,
  input  wire logic [9:0] want,
  output logic      [9:0] pins
);
  // sensors and start reach the physical pins one edge after the request
  always_ff @(posedge core_clk) begin
    pins <= want;
  end
endmodule

// file: wrap_home_sva.sv
/*
  checker for the wrap and home block.
  assumes it is bound to the top module ports.
*/
`timescale 1ns/1ps
module wrap_home_chk (
  input wire logic               core_clk,
  input wire logic               resetn,
  input wire logic               avs_read,
  input wire logic               avs_write,
  input wire logic               avs_waitrequest,
  input wire logic               step_pulse,
  input wire logic               step_dir,
  input wire logic signed [31:0] position,
  input wire logic               wrap_zero_output,
  input wire logic               home_sensor_input,
  input wire logic               fast_homing_cmd
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // a write taken at this edge, at any address, is treated as a possible position preset
  wire logic preset = avs_write && !avs_waitrequest;
  // position moves only by a step or a preset
  pos_hold_a: assert property (!step_pulse && !preset |=> $stable(position))
    else $error("position moved without step");
  step_up_a: assert property (step_pulse && !step_dir && !preset |=>
    position == $past(position) + 1 || position < $past(position))
    else $error("up step gave bad position");
  step_down_a: assert property (step_pulse && step_dir && !preset |=>
    position == $past(position) - 1 || position > $past(position))
    else $error("down step gave bad position");
  zero_pos_a: assert property (wrap_zero_output |-> position == 0)
    else $error("zero pulse off zero");
  zero_cause_a: assert property (wrap_zero_output |-> $past(step_pulse))
    else $error("zero pulse without step");
  sensor_fast_a: assert property (!(home_sensor_input && fast_homing_cmd))
    else $error("home sensor and fast homing both high");
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer after one wait cycle");
  bus_release_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
endmodule
bind wrap_home wrap_home_chk chk_i (.core_clk(core_clk), .resetn(resetn), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .step_pulse(step_pulse),
  .step_dir(step_dir), .position(position), .wrap_zero_output(wrap_zero_output),
  .home_sensor_input(home_sensor_input), .fast_homing_cmd(fast_homing_cmd));

// file: wrap_home_bench.sv
/*
  self-checking bench for the wrap and home block.
  assumes host_pins drives the direct inputs and the checker is bound.
*/
`timescale 1ns/1ps
module wrap_home_bench;
  logic              core_clk, resetn, avs_read, avs_write, step_pulse, step_dir, avs_waitrequest;
  logic              wrap_zero_output, home_start, home_sensor_input, plus_limit_input;
  logic              minus_limit_input, fast_homing_cmd, wr;
  logic [7:0]        avs_address;
  logic [3:0]        avs_byteenable;
  logic [31:0]       avs_writedata, avs_readdata, q;
  logic [9:0]        want, direct_input;
  logic signed [31:0] position;
  int                mismatches, n_compared, lo, hi, p;
  logic [7:0]        ra[8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h1c, 8'h18, 8'h24};
  logic [31:0]       rv[8] = '{1, 10, 5000, 0, 1000, 32'h9873, 0, 0};
  wrap_home #(.din_n(10)) wrap_home_i (.core_clk, .resetn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .step_pulse, .step_dir,
    .direct_input, .position, .wrap_zero_output, .home_start, .home_sensor_input,
    .plus_limit_input, .minus_limit_input, .fast_homing_cmd);
  host_pins host_pins_i (.core_clk(core_clk), .want(want), .pins(direct_input));
  // one bus cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // expected next position after one step
  function automatic int nxt(int v, logic d);
    if (!d) return (wr && v + 1 >= hi) ? lo : v + 1;
    return (wr && v - 1 < lo) ? hi - 1 : v - 1;
  endfunction
  task automatic step(input logic d);
    step_pulse <= 1'b1;
    step_dir <= d;
    @(posedge core_clk);
    step_pulse <= 1'b0;
    @(posedge core_clk);
    p = nxt(p, d);
    chk("position", position, p);
    chk("zero pulse", wrap_zero_output, wr && p == 0);
  endtask
  // set window and preset inside it
  task automatic win(input int rng, input int res, input int rat, input int off);
    bus(1'b1, 8'h04, rng);
    bus(1'b1, 8'h10, res);
    bus(1'b1, 8'h08, rat);
    bus(1'b1, 8'h0c, off);
    lo = off - rng * res * rat / 10000;
    hi = lo + rng * res;
    p = lo + 1;
    bus(1'b1, 8'h14, p);
  endtask
  task automatic hin(input logic [9:0] v, input logic [4:0] e);
    want <= v;
    repeat (6) @(posedge core_clk);
    chk("home", {home_start, home_sensor_input, plus_limit_input, minus_limit_input, fast_homing_cmd}, e);
  endtask
  task automatic stop_test;
    if (mismatches == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // clock source
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    stop_test;
  end
  // main sequence
  initial begin
    {resetn, avs_read, avs_write, step_pulse, step_dir, avs_address, avs_writedata, want} <= '0;
    avs_byteenable <= 4'hf;
    wr = 1'b1;
    void'($urandom(29827));
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, ra[i], 0);
      chk("reset value", q, rv[i]);
    end
    bus(1'b1, 8'h08, 12000);
    bus(1'b0, 8'h08, 0);
    chk("ratio limit", q, 10000);
    bus(1'b1, 8'h0c, -3);
    bus(1'b0, 8'h0c, 0);
    chk("offset sign", q, -3);
    avs_byteenable <= 4'h3;
    bus(1'b1, 8'h0c, 5);
    avs_byteenable <= 4'hf;
    bus(1'b0, 8'h0c, 0);
    chk("partial write", q, -3);
    for (int k = 0; k < 4; k++) begin
      win(k + 1, 3, k == 0 ? 0 : k == 1 ? 10000 : $urandom_range(10000), $urandom_range(8) - 4);
      repeat (30) step($urandom_range(1));
    end
    bus(1'b1, 8'h00, 0);
    wr = 1'b0;
    repeat (20) step(1'b0);
    bus(1'b1, 8'h00, 1);
    wr = 1'b1;
    p = lo + 1;
    bus(1'b1, 8'h14, p);
    repeat (3) step(1'b0);
    hin(10'h008, 5'h10);
    hin(10'h080, 5'h08);
    hin(10'h100, 5'h04);
    hin(10'h200, 5'h02);
    bus(1'b0, 8'h20, 0);
    chk("status", q, 32'h08);
    bus(1'b1, 8'h18, 1);
    hin(10'h000, 5'h10);
    bus(1'b1, 8'h18, 0);
    bus(1'b1, 8'h00, 3);
    hin(10'h080, 5'h01);
    bus(1'b1, 8'h00, 5);
    hin(10'h008, 5'h00);
    stop_test;
  end
endmodule
